// [hw/smt_aux_timer.sv]
// Purpose: Free-running auxiliary timer with prescaler and period match
// Assumes: Software loads the count directly; otherwise only reset and a period match clear it
// Notes: Match pulse lasts one cycle, count restarts at zero
`timescale 1ns/1ps
`default_nettype none
module smt_aux_timer
    import smt_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic run,
    input wire logic [1:0] prescale,
    input wire logic [W-1:0] period_limit,
    input wire logic load,
    input wire logic [W-1:0] load_value,
    output logic [W-1:0] count,
    output logic match
);
    logic [3:0] pre_q, pre_d, pre_lim;
    logic [W-1:0] cnt_q, cnt_d;
    logic match_q, match_d;

    always_comb begin
        pre_lim = (prescale == SMT_PRE_DIV1) ? SMT_PRE_LIM1 :
                  (prescale == SMT_PRE_DIV4) ? SMT_PRE_LIM4 : SMT_PRE_LIM16;
        pre_d = pre_q;
        cnt_d = cnt_q;
        match_d = 1'b0;
        if (load) begin
            cnt_d = load_value;
            pre_d = 4'h0;
        end else if (run) begin
            // Counts on regardless of any serial activity
            if (pre_q >= pre_lim) begin
                pre_d = 4'h0;
                if (cnt_q == period_limit) begin
                    cnt_d = '0;
                    match_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end else begin
                pre_d = pre_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pre_q <= 4'h0;
            cnt_q <= '0;
            match_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            match_q <= match_d;
        end
    end

    assign count = cnt_q;
    assign match = match_q;
endmodule
`default_nettype wire

// [hw/smt_pkg.sv]
// Purpose: Shared constants of the timer-clocked serial master
// Assumes: 32-bit AXI4-Lite register bus, byte offsets below
// Notes: All registers hold their fields in the low byte
package smt_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] SMT_OFF_CTRL = 8'h00;
    localparam logic [7:0] SMT_OFF_TIMER_CONTROL = 8'h04;
    localparam logic [7:0] SMT_OFF_TIMER_COUNT = 8'h08;
    localparam logic [7:0] SMT_OFF_TIMER_PERIOD_LIMIT = 8'h0C;
    localparam logic [7:0] SMT_OFF_SHIFT_BUFFER = 8'h10;
    localparam logic [7:0] SMT_OFF_IRQ_FLAGS = 8'h14;
    localparam logic [7:0] SMT_OFF_IRQ_MASK = 8'h18;
    localparam logic [7:0] SMT_OFF_STATUS = 8'h1C;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int SMT_BIT_PORT_ENABLE = 0;
    localparam int SMT_BIT_TIMER_RUN_ENABLE = 0;
    localparam int SMT_POS_PRESCALE = 1;
    localparam int SMT_BIT_DONE = 0;
    localparam int SMT_BIT_COLLISION = 1;
    localparam int SMT_BIT_BUSY = 0;
    localparam int SMT_IRQ_W = 2;

    // ****************************************
    // Reset values and encodings
    // ****************************************
    localparam logic [7:0] SMT_RST_PERIOD_LIMIT = 8'hFF;
    localparam logic [1:0] SMT_PRE_DIV1 = 2'h0;
    localparam logic [1:0] SMT_PRE_DIV4 = 2'h1;
    localparam logic [3:0] SMT_PRE_LIM1 = 4'h0;
    localparam logic [3:0] SMT_PRE_LIM4 = 4'h3;
    localparam logic [3:0] SMT_PRE_LIM16 = 4'hF;
    localparam logic [1:0] SMT_RESP_OKAY = 2'h0;
    localparam logic [1:0] SMT_RESP_SLVERR = 2'h2;
    localparam int SMT_BITS_PER_BYTE = 8;
endpackage

// [hw/smt_spi_master.sv]
// Purpose: Serial master transmit path clocked by aux timer match / 2
// Assumes: AXI4-Lite slave, one write and one read in flight at most
// Notes: Mode 0, MSb first; serial_in sampled on rising clock edge
`timescale 1ns/1ps
`default_nettype none
module smt_spi_master
    import smt_pkg::*;
#(
    parameter int TW = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic serial_clk,
    output logic serial_out,
    input wire logic serial_in,
    output logic irq
);
    // ****************************************
    // State
    // ****************************************
    logic awready_q, awready_d, wready_q, wready_d;
    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [7:0] waddr_q, waddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    logic port_en_q, port_en_d;
    logic run_q, run_d;
    logic [1:0] presc_q, presc_d;
    logic [TW-1:0] period_q, period_d;
    logic [SMT_IRQ_W-1:0] flags_q, flags_d, mask_q, mask_d, ev_set;
    logic irq_q, irq_d;

    logic busy_q, busy_d, sclk_q, sclk_d, sout_q, sout_d, sample_q, sample_d;
    logic [7:0] shreg_q, shreg_d, rxbuf_q, rxbuf_d;
    logic [2:0] bitn_q, bitn_d;
    logic [2:0] sync_q;
    logic sin_q, sin_d;

    logic wr_fire, wr_ok, rd_ok, tload;
    logic [7:0] tload_val;
    logic [TW-1:0] tcount;
    logic tmatch;

    // ****************************************
    // Auxiliary timer
    // ****************************************
    smt_aux_timer #(
        .W(TW)
    ) u_timer (
        .clk(clk),
        .reset(reset),
        .run(run_q),
        .prescale(presc_q),
        .period_limit(period_q),
        .load(tload),
        .load_value(tload_val[TW-1:0]),
        .count(tcount),
        .match(tmatch)
    );

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        awready_d = awready_q;
        wready_d = wready_q;
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        port_en_d = port_en_q;
        run_d = run_q;
        presc_d = presc_q;
        period_d = period_q;
        mask_d = mask_q;
        busy_d = busy_q;
        sclk_d = sclk_q;
        sout_d = sout_q;
        sample_d = sample_q;
        shreg_d = shreg_q;
        rxbuf_d = rxbuf_q;
        bitn_d = bitn_q;
        ev_set = '0;
        tload = 1'b0;
        tload_val = wdata_q[7:0];
        wr_ok = 1'b1;
        rd_ok = 1'b1;

        // Input filter: accept a change once both late stages agree
        sin_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : sin_q;

        // Address and data channels taken independently
        if (s_axi_awvalid && awready_q) begin
            aw_got_d = 1'b1;
            waddr_d = s_axi_awaddr;
            awready_d = 1'b0;
        end
        if (s_axi_wvalid && wready_q) begin
            w_got_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
            wready_d = 1'b0;
        end

        // Serial engine, stepped only by timer matches
        if (busy_q && tmatch) begin
            sclk_d = ~sclk_q;
            if (!sclk_q) begin
                sample_d = sin_q;
            end else if (bitn_q == 3'(SMT_BITS_PER_BYTE - 1)) begin
                busy_d = 1'b0;
                rxbuf_d = {shreg_q[6:0], sample_q};
                ev_set[SMT_BIT_DONE] = 1'b1;
            end else begin
                shreg_d = {shreg_q[6:0], sample_q};
                sout_d = shreg_q[6];
                bitn_d = bitn_q + 3'h1;
            end
        end

        // Register write once both halves are held
        wr_fire = aw_got_q && w_got_q && !bvalid_q;
        if (wr_fire) begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bvalid_d = 1'b1;
            if (wstrb_q[0]) begin
                case (waddr_q)
                    SMT_OFF_CTRL: port_en_d = wdata_q[SMT_BIT_PORT_ENABLE];
                    SMT_OFF_TIMER_CONTROL: begin
                        run_d = wdata_q[SMT_BIT_TIMER_RUN_ENABLE];
                        presc_d = wdata_q[SMT_POS_PRESCALE +: 2];
                    end
                    SMT_OFF_TIMER_COUNT: tload = 1'b1;
                    SMT_OFF_TIMER_PERIOD_LIMIT: period_d = wdata_q[TW-1:0];
                    SMT_OFF_SHIFT_BUFFER: begin
                        // Timer is left alone here, so first bit may be short
                        if (busy_q || !port_en_q) begin
                            ev_set[SMT_BIT_COLLISION] = 1'b1;
                        end else begin
                            busy_d = 1'b1;
                            shreg_d = wdata_q[7:0];
                            sout_d = wdata_q[7];
                            sclk_d = 1'b0;
                            bitn_d = 3'h0;
                        end
                    end
                    SMT_OFF_IRQ_FLAGS: ;
                    SMT_OFF_IRQ_MASK: mask_d = wdata_q[SMT_IRQ_W-1:0];
                    SMT_OFF_STATUS: ;
                    default: wr_ok = 1'b0;
                endcase
            end
            bresp_d = wr_ok ? SMT_RESP_OKAY : SMT_RESP_SLVERR;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        awready_d = awready_d && !bvalid_d || (!aw_got_d && !bvalid_d);
        wready_d = wready_d && !bvalid_d || (!w_got_d && !bvalid_d);

        // Read channel
        if (s_axi_arvalid && arready_q) begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rdata_d = 32'h0000_0000;
            case (s_axi_araddr)
                SMT_OFF_CTRL: rdata_d[SMT_BIT_PORT_ENABLE] = port_en_q;
                SMT_OFF_TIMER_CONTROL: begin
                    rdata_d[SMT_BIT_TIMER_RUN_ENABLE] = run_q;
                    rdata_d[SMT_POS_PRESCALE +: 2] = presc_q;
                end
                SMT_OFF_TIMER_COUNT: rdata_d[TW-1:0] = tcount;
                SMT_OFF_TIMER_PERIOD_LIMIT: rdata_d[TW-1:0] = period_q;
                SMT_OFF_SHIFT_BUFFER: rdata_d[7:0] = rxbuf_q;
                SMT_OFF_IRQ_FLAGS: rdata_d[SMT_IRQ_W-1:0] = flags_q;
                SMT_OFF_IRQ_MASK: rdata_d[SMT_IRQ_W-1:0] = mask_q;
                SMT_OFF_STATUS: rdata_d[SMT_BIT_BUSY] = busy_q;
                default: rd_ok = 1'b0;
            endcase
            rresp_d = rd_ok ? SMT_RESP_OKAY : SMT_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end

        // Sticky flags, write one to clear, a new event wins
        flags_d = flags_q;
        if (wr_fire && wstrb_q[0] && waddr_q == SMT_OFF_IRQ_FLAGS) begin
            flags_d = flags_q & ~wdata_q[SMT_IRQ_W-1:0];
        end
        flags_d = flags_d | ev_set;
        irq_d = |(flags_d & mask_d);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= SMT_RESP_OKAY;
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= SMT_RESP_OKAY;
            port_en_q <= 1'b0;
            run_q <= 1'b0;
            presc_q <= SMT_PRE_DIV1;
            period_q <= SMT_RST_PERIOD_LIMIT[TW-1:0];
            flags_q <= '0;
            mask_q <= '0;
            irq_q <= 1'b0;
            busy_q <= 1'b0;
            sclk_q <= 1'b0;
            sout_q <= 1'b0;
            sample_q <= 1'b0;
            shreg_q <= 8'h00;
            rxbuf_q <= 8'h00;
            bitn_q <= 3'h0;
            sync_q <= 3'h0;
            sin_q <= 1'b0;
        end else begin
            awready_q <= awready_d;
            wready_q <= wready_d;
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            port_en_q <= port_en_d;
            run_q <= run_d;
            presc_q <= presc_d;
            period_q <= period_d;
            flags_q <= flags_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
            busy_q <= busy_d;
            sclk_q <= sclk_d;
            sout_q <= sout_d;
            sample_q <= sample_d;
            shreg_q <= shreg_d;
            rxbuf_q <= rxbuf_d;
            bitn_q <= bitn_d;
            sync_q <= {sync_q[1:0], serial_in};
            sin_q <= sin_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign serial_clk = sclk_q;
    assign serial_out = sout_q;
    assign irq = irq_q;
endmodule
`default_nettype wire

// [tb/smt_spi_master_props.sv]
// Purpose: Port-level checker for the timer-clocked serial master
// Assumes: Sees only top-level ports, single clock domain
// Notes: Bound into smt_spi_master at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module smt_spi_master_props
    import smt_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_clk,
    input wire logic serial_out,
    input wire logic irq
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_out_clk_low: assert property ($changed(serial_out) |-> !serial_clk)
        else $error("serial_out changed while serial_clk high");
    a_rise_hold: assert property ($rose(serial_clk) |=> serial_clk)
        else $error("serial_clk high for one cycle only");
    a_fall_hold: assert property ($fell(serial_clk) |=> !serial_clk)
        else $error("serial_clk low for one cycle only");
    a_irq_clear_write: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
        else $error("irq dropped without a register write");
    a_bresp_delay: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_rvalid_delay: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    c_irq: cover property ($rose(irq));
    c_sclk: cover property ($rose(serial_clk));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == SMT_RESP_SLVERR);
endmodule
bind smt_spi_master smt_spi_master_props u_smt_spi_master_props (.clk(clk), .reset(reset),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .serial_clk(serial_clk), .serial_out(serial_out), .irq(irq));
`default_nettype wire

// [tb/smt_spi_slave.sv]
// Purpose: Behavioural serial slave facing the master
// Assumes: Mode 0, MSb first
// Notes: Fills with a changing pattern once its byte is out
`timescale 1ns/1ps
`default_nettype none
module smt_spi_slave (
    input wire logic serial_clk,
    input wire logic serial_out,
    input wire logic load,
    input wire logic [7:0] tx_byte,
    output logic serial_in,
    output logic [7:0] rx_byte
);
    // ****************************************
    // Shift logic
    // ****************************************
    logic [7:0] sr = 8'h00;
    assign serial_in = sr[7];
    always @(posedge serial_clk) rx_byte <= {rx_byte[6:0], serial_out};
    always @(negedge serial_clk or posedge load) begin
        if (load) sr <= tx_byte;
        else sr <= {sr[6:0], ~sr[0]};
    end
endmodule
`default_nettype wire

// [tb/spi_master_timer_clocked_tx_test.sv]
// Purpose: Self-checking bench for the timer-clocked serial master
// Assumes: AXI4-Lite master tasks, slave model on the serial side
// Notes: Small period limits keep transfers short
`timescale 1ns/1ps
`default_nettype none
module spi_master_timer_clocked_tx_test
    import smt_pkg::*;
();
    // ****************************************
    // Bench
    // ****************************************
    logic clk = 1'h0, reset = 1'h1, load = 1'h0, sp = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, stx = 8'h00, srx;
    logic [31:0] wdata = 32'h0, rdata, rdat;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, sclk, sout, sin, irq;
    logic [1:0] bresp, rresp, resp;
    int error_cnt = 0, num_checks = 0, cyc = 0, last = 0, period = 0;
    always #5 clk = ~clk;
    smt_spi_master #(.TW(8)) u_smt_spi_master (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .serial_clk(sclk), .serial_out(sout), .serial_in(sin), .irq(irq));
    smt_spi_slave u_smt_spi_slave (.serial_clk(sclk), .serial_out(sout), .load(load), .tx_byte(stx),
        .serial_in(sin), .rx_byte(srx));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        sp <= sclk;
        if (sclk && !sp) begin
            period <= cyc - last;
            last <= cyc;
        end
    end
    task automatic final_report();
        if (error_cnt == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 3000) begin
            error_cnt++;
            final_report();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n, dly;
        logic hs;
        n = 0;
        hs = 1'b0;
        dly = $urandom_range(5, 1);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            hs = bvalid && bready;
            // Late ready at times, so the response must wait
            if (n >= dly && !hs) bready <= 1'h1;
        end while (!hs && n < 3000);
        resp = bresp;
        bready <= 1'h0;
        tmo(n);
    endtask
    task automatic rd(input logic [7:0] a);
        int n, dly;
        logic hs;
        n = 0;
        hs = 1'b0;
        dly = $urandom_range(5, 1);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'h0;
            hs = rvalid && rready;
            if (n >= dly && !hs) rready <= 1'h1;
        end while (!hs && n < 3000);
        rdat = rdata;
        resp = rresp;
        rready <= 1'h0;
        tmo(n);
    endtask
    task automatic poll();
        int n;
        n = 0;
        do begin
            rd(SMT_OFF_IRQ_FLAGS);
            n++;
        end while (rdat[0] !== 1'h1 && n < 3000);
        tmo(n);
    endtask
    function automatic int bit_cyc(input int lim, input int ps);
        return 2 * (lim + 1) * (ps == 0 ? 1 : ps == 1 ? 4 : 16);
    endfunction
    initial begin
        logic [7:0] tx, sl;
        int lim, n;
        void'($urandom(32'hE2CE));
        repeat (3) @(posedge clk);
        reset <= 1'h0;
        rd(SMT_OFF_TIMER_PERIOD_LIMIT);
        chk("limit", 32'(SMT_RST_PERIOD_LIMIT), rdat);
        rd(SMT_OFF_TIMER_CONTROL);
        chk("tctl", 32'h0, rdat);
        wr(8'h40, 32'h1);
        chk("bresp", SMT_RESP_SLVERR, resp);
        rd(8'h40);
        chk("rresp", SMT_RESP_SLVERR, resp);
        wr(SMT_OFF_SHIFT_BUFFER, 32'h81);
        rd(SMT_OFF_IRQ_FLAGS);
        chk("off collision", 32'h2, rdat);
        wr(SMT_OFF_CTRL, 32'h1);
        wr(SMT_OFF_IRQ_MASK, 32'h1);
        for (int ps = 0; ps < 4; ps++) begin
            // Half bit must outlast the input synchroniser
            lim = $urandom_range(6, 4);
            tx = $urandom();
            sl = $urandom();
            wr(SMT_OFF_TIMER_PERIOD_LIMIT, lim);
            wr(SMT_OFF_IRQ_FLAGS, 32'h3);
            chk("irq clr", 32'h0, irq);
            rd(SMT_OFF_SHIFT_BUFFER);
            wr(SMT_OFF_TIMER_CONTROL, ps << 1);
            wr(SMT_OFF_TIMER_COUNT, 32'h0);
            stx <= sl;
            load <= 1'h1;
            @(posedge clk);
            load <= 1'h0;
            wr(SMT_OFF_SHIFT_BUFFER, tx);
            repeat (20) @(posedge clk);
            chk("sclk idle", 32'h0, sclk);
            wr(SMT_OFF_TIMER_CONTROL, (ps << 1) | 1);
            poll();
            chk("irq", 32'h1, irq);
            repeat (30) @(posedge clk);
            rd(SMT_OFF_IRQ_FLAGS);
            chk("done held", 32'h1, rdat[0]);
            chk("slave rx", tx, srx);
            chk("bit period", bit_cyc(lim, ps), period);
            rd(SMT_OFF_SHIFT_BUFFER);
            chk("master rx", sl, rdat);
        end
        wr(SMT_OFF_IRQ_FLAGS, 32'h3);
        wr(SMT_OFF_TIMER_PERIOD_LIMIT, 32'h7);
        wr(SMT_OFF_TIMER_CONTROL, 32'h0);
        wr(SMT_OFF_TIMER_COUNT, 32'h6);
        wr(SMT_OFF_SHIFT_BUFFER, 32'h3C);
        rd(SMT_OFF_TIMER_COUNT);
        chk("count kept", 32'h6, rdat);
        wr(SMT_OFF_TIMER_CONTROL, 32'h1);
        n = 0;
        while (!sclk && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk("short msb", 32'h1, n < 8);
        wr(SMT_OFF_SHIFT_BUFFER, 32'h55);
        rd(SMT_OFF_IRQ_FLAGS);
        chk("collision", 32'h1, rdat[1]);
        rd(SMT_OFF_STATUS);
        chk("busy", 32'h1, rdat[0]);
        poll();
        chk("tx kept", 32'h3C, srx);
        final_report();
    end
endmodule
`default_nettype wire
